// File: sim/stc_pin_load.sv
`timescale 1ns/1ps

module stc_pin_load
(
    input wire logic pin_drv,
    input wire logic pin_en,
    output logic pin_level
);
    // a released pin floats to the board pull-up, never keeps the last level
    assign pin_level = pin_en ? pin_drv : 1'b1;
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps

module testbench;
    import stc_pkg::*;
    typedef struct packed
    {
        logic [7:0] c1;
        logic [15:0] a;
        logic [7:0] p;
        logic [15:0] win;
        logic [15:0] hi;
        logic [1:0] st;
    } stc_row_t;
    localparam int LIMIT = 100000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tm_out;
    logic tm_out_en;
    logic pin;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    stc_row_t rows [14];

    stc_timer i_stc_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tm_out(tm_out), .tm_out_en(tm_out_en));
    stc_pin_load i_stc_pin_load (.pin_drv(tm_out), .pin_en(tm_out_en), .pin_level(pin));

    // 4 ns clock
    initial
    begin
        forever #2 pclk = ~pclk;
    end

    // hang guard, well above the longest run of about 80k cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            results();
        end
    end

    task results();
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high at a rising edge
    // answer taken at that same edge, release follows it; only the hang guard ends a wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    // high cycles of the pin over a window; phase free for whole periods
    task meas(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(negedge pclk);
            if (pin === 1'b1)
                h++;
        end
    endtask

    initial
    begin
        logic [31:0] q;
        logic e;
        int h;
        logic [7:0] ra [8];
        ra = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_CMPA_LO, ADDR_CMPA_HI, ADDR_CMPP, ADDR_STATUS};
        // ctrl1, compare A, compare P, window, expected high cycles, expected flags
        rows[0] = '{8'hA9, 16'd64, 8'd1, 16'd512, 16'd128, 2'd3};
        rows[1] = '{8'hA0, 16'd64, 8'd1, 16'd512, 16'd384, 2'd3};
        rows[2] = '{8'hAC, 16'd64, 8'd1, 16'd512, 16'd384, 2'd3};
        rows[3] = '{8'hA8, 16'd300, 8'd1, 16'd512, 16'd512, 2'd2};
        rows[4] = '{8'hAA, 16'd1000, 8'd2, 16'd2000, 16'd1024, 2'd3};
        rows[5] = '{8'h98, 16'd64, 8'd1, 16'd512, 16'd512, 2'd3};
        rows[6] = '{8'h88, 16'd64, 8'd1, 16'd512, 16'd0, 2'd3};
        rows[7] = '{8'h30, 16'd64, 8'd1, 16'd512, 16'd256, 2'd3};
        rows[8] = '{8'h31, 16'd300, 8'd1, 16'd1200, 16'd600, 2'd1};
        rows[9] = '{8'h18, 16'd64, 8'd1, 16'd512, 16'd0, 2'd3};
        rows[10] = '{8'h20, 16'd64, 8'd1, 16'd512, 16'd512, 2'd3};
        rows[11] = '{8'h08, 16'd64, 8'd1, 16'd512, 16'd512, 2'd3};
        rows[12] = '{8'h00, 16'd64, 8'd1, 16'd512, 16'd0, 2'd3};
        rows[13] = '{8'hF0, 16'd64, 8'd1, 16'd512, 16'd512, 2'd3};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // every register reads zero out of reset
        foreach (ra[k])
        begin
            apb(1'b0, ra[k], 32'h0, q, e);
            chk(q, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(ADDR_CNT_HI, 32'hFF);
        apb(1'b0, ADDR_CNT_HI, 32'h0, q, e);
        chk(q, 32'h0);
        wr(ADDR_CMPA_HI, 32'h5A);
        apb(1'b0, ADDR_CMPA_HI, 32'h0, q, e);
        chk(q, 32'h5A);
        // each row: stop, program, clear flags, start, settle, measure
        foreach (rows[i])
        begin
            wr(ADDR_CTRL0, 32'h0);
            wr(ADDR_CMPA_LO, {24'h0, rows[i].a[7:0]});
            wr(ADDR_CMPA_HI, {24'h0, rows[i].a[15:8]});
            wr(ADDR_CMPP, {24'h0, rows[i].p});
            wr(ADDR_CTRL1, {24'h0, rows[i].c1});
            wr(ADDR_STATUS, 32'h3);
            wr(ADDR_CTRL0, 32'h1 << CTRL0_RUN_BIT);
            repeat (int'(rows[i].win) / 2 + 20) @(posedge pclk);
            meas(int'(rows[i].win), h);
            chk(32'(h), {16'h0, rows[i].hi});
            chk({31'h0, tm_out_en}, {31'h0, rows[i].c1[7:6] != MODE_TMR});
            apb(1'b0, ADDR_STATUS, 32'h0, q, e);
            chk(q, {30'h0, rows[i].st});
        end
        // compare P zero: counter overflows, period 65536
        wr(ADDR_CTRL0, 32'h0);
        wr(ADDR_CMPA_LO, 32'h1);
        wr(ADDR_CMPA_HI, 32'h0);
        wr(ADDR_CMPP, 32'h0);
        wr(ADDR_CTRL1, 32'h30);
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_CTRL0, 32'h1 << CTRL0_RUN_BIT);
        repeat (10) @(negedge pclk);
        chk({31'h0, pin}, 32'h1);
        h = 0;
        while (pin === 1'b1 && h < 70000)
        begin
            @(negedge pclk);
            h++;
        end
        chk({31'h0, h > 65500 && h <= 65536}, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0, q, e);
        chk(q, 32'h3);
        apb(1'b0, ADDR_CNT_HI, 32'h0, q, e);
        chk(q, 32'h0);
        // clock enable low freezes the counter: only the four enabled edges between samples count
        apb(1'b0, ADDR_CNT_LO, 32'h0, q, e);
        h = int'(q[7:0]);
        clk_en <= 1'b0;
        repeat (50) @(posedge pclk);
        clk_en <= 1'b1;
        apb(1'b0, ADDR_CNT_LO, 32'h0, q, e);
        chk({24'h0, q[7:0] - 8'(h)}, 32'h4);
        // divide by four without a run rise: four clocks between samples give one tick
        wr(ADDR_CTRL0, (32'h1 << CTRL0_RUN_BIT) | (32'h1 << CTRL0_PRESC_LSB));
        apb(1'b0, ADDR_CNT_LO, 32'h0, q, e);
        h = int'(q[7:0]);
        apb(1'b0, ADDR_CNT_LO, 32'h0, q, e);
        chk({24'h0, q[7:0] - 8'(h)}, 32'h1);
        // reset in mid-run puts everything back
        wr(ADDR_CMPA_HI, 32'h77);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk({30'h0, tm_out, tm_out_en}, 32'h0);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CMPA_HI, 32'h0, q, e);
        chk(q, 32'h0);
        results();
    end
endmodule

// File: src/stc_pkg.sv
package stc_pkg;
    // register map, one aligned word each
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_CMPP = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1C;

    // control zero fields
    localparam int CTRL0_RUN_BIT = 3;
    localparam int CTRL0_PRESC_LSB = 4;
    // control one fields
    localparam int CTRL1_MODE_LSB = 6;
    localparam int CTRL1_ACT_LSB = 4;
    localparam int CTRL1_OC_BIT = 3;
    localparam int CTRL1_INV_BIT = 2;
    localparam int CTRL1_SWAP_BIT = 1;
    localparam int CTRL1_CCLR_BIT = 0;
    // status fields, write one to clear
    localparam int STATUS_A_BIT = 0;
    localparam int STATUS_P_BIT = 1;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // mode field codes
    localparam logic [1:0] MODE_CMP = 2'b00;
    localparam logic [1:0] MODE_PWM = 2'b10;
    localparam logic [1:0] MODE_TMR = 2'b11;

    // output action codes in compare mode
    localparam logic [1:0] ACT_NONE = 2'b00;
    localparam logic [1:0] ACT_LOW = 2'b01;
    localparam logic [1:0] ACT_HIGH = 2'b10;
    localparam logic [1:0] ACT_TOGGLE = 2'b11;
    // output action codes in pwm mode; 1x runs the waveform
    localparam logic [1:0] ACT_FORCE_LOW = 2'b00;
    localparam logic [1:0] ACT_FORCE_HIGH = 2'b01;

    // compare p granule: 256 timer clocks, full span 65536
    localparam int P_SHIFT = 8;
    localparam logic [16:0] FULL_SPAN = 17'h10000;
    // prescaler: divide by 4 to the power of the select field
    localparam int PRESC_W = 6;
endpackage

// File: src/stc_timer.sv
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps

// How it works
// RULE1: compare A is two reset-zero byte registers
// RULE2: compare P matches counter bits fifteen to eight
// RULE3: P period is value times 256, zero 65536
// RULE4: P zero lets counter overflow instead
// RULE5: mode field 00 compare, 11 timer, 10 pwm
// RULE6: clear-select low clears on P, sets both flags
// RULE7: clear-select high clears on A, no P flag
// RULE8: compare A zero overflows without A flag
// RULE9: pin changes only on compare A match
// RULE10: action field sets, clears, toggles or holds pin
// RULE11: run rising edge loads pin initial level
// RULE12: timer mode counts alike, pin not driven
// RULE13: pwm uses one comparator period, other duty
// RULE14: pwm ignores clear-select
// RULE15: pwm sets A and P flags on matches
// RULE16: pwm polarity, force levels and inversion
// RULE17: swap low: period from P, duty from A
// RULE18: duty at or above period gives full duty
// RULE19: swap high: period from A, duty from P
// RULE20: pwm counting continues while pin is forced
// RULE21: initial level bit meaning per mode
// RULE22: counter readable as two read-only bytes
// RULE23: run rise clears counter, ticks increment it
module stc_timer
#(
    parameter int CNT_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [stc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tm_out,
    output logic tm_out_en
);
    import stc_pkg::*;

    typedef struct packed {
        logic run;
        logic run_d;
        logic [1:0] presc_sel;
        logic [PRESC_W-1:0] presc;
        logic [1:0] mode;
        logic [1:0] act;
        logic oc;
        logic inv;
        logic swap;
        logic cclr;
        logic [CNT_W-1:0] cnt;
        logic [7:0] cmpa_lo;
        logic [7:0] cmpa_hi;
        logic [7:0] cmpp;
        logic flag_a;
        logic flag_p;
        logic out_level;
        logic pin;
        logic pin_en;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } stc_state_t;

    stc_state_t st;
    stc_state_t next_st;

    // span of compare P in timer clocks, zero meaning the full range
    function automatic logic [16:0] p_span(input logic [7:0] p);
        p_span = (p == 8'h00) ? FULL_SPAN : {1'b0, p, 8'h00};
    endfunction

    // last prescaler count before a timer tick
    function automatic logic [PRESC_W-1:0] presc_limit(input logic [1:0] sel);
        logic [PRESC_W-1:0] one;
        one = {{(PRESC_W-1){1'b0}}, 1'b1};
        presc_limit = (one << (2 * sel)) - one;
    endfunction

    // address decode for the error answer only; the read mux decodes paddr in its own case
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_CTRL0) || (a == ADDR_CTRL1) || (a == ADDR_CNT_LO) ||
                    (a == ADDR_CNT_HI) || (a == ADDR_CMPA_LO) || (a == ADDR_CMPA_HI) ||
                    (a == ADDR_CMPP) || (a == ADDR_STATUS);
    endfunction

    logic [15:0] cmp_a;
    logic [16:0] nxt17;
    logic [15:0] nxt16;
    logic run_rise;
    logic tick;
    logic match_a;
    logic p_evt;
    logic clr;
    logic [16:0] duty;
    logic [16:0] period;
    logic pwm_active;
    logic cm_like;
    logic wr_fire;
    logic [31:0] rd_val;

    // comparator and counter terms
    always_comb
    begin
        cmp_a = {st.cmpa_hi, st.cmpa_lo}; // [RULE1]
        nxt17 = {1'b0, st.cnt} + 17'h00001;
        nxt16 = nxt17[15:0];
        run_rise = st.run && !st.run_d;
        tick = clk_en && st.run && !run_rise && (st.presc == presc_limit(st.presc_sel)); // [RULE23]
        match_a = (cmp_a != 16'h0000) && (nxt16 == cmp_a); // [RULE8]
        // full 16-bit compare against P with a zero low byte, so events land on 256-clock multiples
        p_evt = (st.cmpp != 8'h00) ? (nxt16 == {st.cmpp, 8'h00}) : nxt17[16]; // [RULE2] [RULE3] [RULE4]
        cm_like = (st.mode != MODE_PWM);
        // pwm picks the period comparator by swap; clear-select unused there
        if (st.mode == MODE_PWM)
        begin
            clr = st.swap ? match_a : p_evt; // [RULE13] [RULE14]
        end
        else
        begin
            clr = st.cclr ? match_a : p_evt; // [RULE6] [RULE7]
        end
        duty = st.swap ? p_span(st.cmpp) : {1'b0, cmp_a}; // [RULE17] [RULE19]
        period = st.swap ? ((cmp_a == 16'h0000) ? FULL_SPAN : {1'b0, cmp_a}) : p_span(st.cmpp);
        // count never reaches period, so duty >= period stays active
        pwm_active = ({1'b0, st.cnt} < duty); // [RULE18]
    end

    // read mux; counter bytes read live, no snapshot latch
    always_comb
    begin
        rd_val = 32'h00000000;
        unique case (paddr)
            ADDR_CTRL0:
            begin
                rd_val[CTRL0_RUN_BIT] = st.run;
                rd_val[CTRL0_PRESC_LSB +: 2] = st.presc_sel;
            end
            ADDR_CTRL1:
            begin
                rd_val[CTRL1_MODE_LSB +: 2] = st.mode;
                rd_val[CTRL1_ACT_LSB +: 2] = st.act;
                rd_val[CTRL1_OC_BIT] = st.oc;
                rd_val[CTRL1_INV_BIT] = st.inv;
                rd_val[CTRL1_SWAP_BIT] = st.swap;
                rd_val[CTRL1_CCLR_BIT] = st.cclr;
            end
            ADDR_CNT_LO: rd_val[7:0] = st.cnt[7:0]; // [RULE22]
            ADDR_CNT_HI: rd_val[7:0] = st.cnt[15:8]; // [RULE22]
            ADDR_CMPA_LO: rd_val[7:0] = st.cmpa_lo;
            ADDR_CMPA_HI: rd_val[7:0] = st.cmpa_hi;
            ADDR_CMPP: rd_val[7:0] = st.cmpp;
            ADDR_STATUS:
            begin
                rd_val[STATUS_A_BIT] = st.flag_a;
                rd_val[STATUS_P_BIT] = st.flag_p;
            end
            default: rd_val = 32'h00000000;
        endcase
    end

    assign wr_fire = clk_en && psel && penable && st.ack && pwrite && !st.err;

    // whole next state; everything holds while clk_en is low
    always_comb
    begin
        next_st = st;
        if (clk_en)
        begin
            // apb: one wait cycle, data and error registered at first access cycle
            if (psel && penable && !st.ack)
            begin
                next_st.ack = 1'b1;
                next_st.err = !is_mapped(paddr);
                next_st.rdata = rd_val;
            end
            else
            begin
                next_st.ack = 1'b0;
            end

            // prescaler and counter
            next_st.run_d = st.run;
            if (run_rise)
            begin
                next_st.presc = '0;
                next_st.cnt = CNT_RST; // [RULE23]
            end
            else if (st.run)
            begin
                next_st.presc = tick ? '0 : st.presc + 1'b1;
                if (tick)
                begin
                    next_st.cnt = clr ? CNT_RST : nxt16; // [RULE6] [RULE7] [RULE12] [RULE20]
                end
            end

            // flag set wins over a software clear in the same cycle
            if (wr_fire && (paddr == ADDR_STATUS))
            begin
                if (pwdata[STATUS_A_BIT])
                begin
                    next_st.flag_a = 1'b0;
                end
                if (pwdata[STATUS_P_BIT])
                begin
                    next_st.flag_p = 1'b0;
                end
            end
            if (tick && match_a)
            begin
                next_st.flag_a = 1'b1; // [RULE6] [RULE15]
            end
            if (tick && p_evt && (!cm_like || !st.cclr))
            begin
                next_st.flag_p = 1'b1; // [RULE6] [RULE7] [RULE15]
            end

            // pin level before inversion
            if (st.mode == MODE_CMP)
            begin
                if (run_rise)
                begin
                    next_st.out_level = st.oc; // [RULE11] [RULE21]
                end
                else if (tick && match_a)
                begin
                    unique case (st.act) // [RULE9] [RULE10]
                        ACT_NONE: next_st.out_level = st.out_level;
                        ACT_LOW: next_st.out_level = 1'b0;
                        ACT_HIGH: next_st.out_level = 1'b1;
                        ACT_TOGGLE: next_st.out_level = !st.out_level;
                    endcase
                end
            end
            else if (st.mode == MODE_PWM)
            begin
                unique case (st.act) // [RULE16] [RULE20]
                    ACT_FORCE_LOW: next_st.out_level = 1'b0;
                    ACT_FORCE_HIGH: next_st.out_level = 1'b1;
                    default: next_st.out_level = st.oc ? pwm_active : !pwm_active; // [RULE21]
                endcase
            end

            // register writes take effect at the completing edge
            if (wr_fire)
            begin
                unique case (paddr)
                    ADDR_CTRL0:
                    begin
                        next_st.run = pwdata[CTRL0_RUN_BIT];
                        next_st.presc_sel = pwdata[CTRL0_PRESC_LSB +: 2];
                    end
                    ADDR_CTRL1:
                    begin
                        next_st.mode = pwdata[CTRL1_MODE_LSB +: 2]; // [RULE5]
                        next_st.act = pwdata[CTRL1_ACT_LSB +: 2];
                        next_st.oc = pwdata[CTRL1_OC_BIT];
                        next_st.inv = pwdata[CTRL1_INV_BIT];
                        next_st.swap = pwdata[CTRL1_SWAP_BIT];
                        next_st.cclr = pwdata[CTRL1_CCLR_BIT];
                    end
                    ADDR_CMPA_LO: next_st.cmpa_lo = pwdata[7:0]; // [RULE1]
                    ADDR_CMPA_HI: next_st.cmpa_hi = pwdata[7:0]; // [RULE1]
                    ADDR_CMPP: next_st.cmpp = pwdata[7:0];
                    default: next_st.run = st.run; // counter and status handled above
                endcase
            end

            // pin flop folds inversion in; timer mode leaves pin to others
            next_st.pin = next_st.out_level ^ next_st.inv; // [RULE16]
            next_st.pin_en = (next_st.mode == MODE_CMP) || (next_st.mode == MODE_PWM); // [RULE12]
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0; // all control, compare and counter reset values are zero
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ack;
    assign pslverr = st.ack && st.err;
    assign tm_out = st.pin;
    assign tm_out_en = st.pin_en;

    // checks
    a_run_rise_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
        clk_en && run_rise |=> (st.cnt == CNT_RST) && !$past(tick))
        else $error("counter not cleared on run rise");

    a_p_clear_cnt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        tick && p_evt && cm_like && !st.cclr |=> st.cnt == CNT_RST)
        else $error("counter not cleared on compare P event");

    a_cclr_no_p: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        clk_en && cm_like && st.cclr && !st.flag_p |=> !st.flag_p)
        else $error("P flag set with clear-select high");

    a_zero_a_noflag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        clk_en && cmp_a == 16'h0000 && !st.flag_a |=> !st.flag_a)
        else $error("A flag set with compare A zero");

    a_pin_hold_p: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        clk_en && st.mode == MODE_CMP && !(tick && match_a) && !run_rise |=> $stable(st.out_level))
        else $error("compare pin changed without A match");

    a_pin_toggle: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        tick && match_a && st.mode == MODE_CMP && st.act == ACT_TOGGLE |=> st.out_level != $past(st.out_level))
        else $error("pin did not toggle on A match");

    a_init_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        clk_en && st.mode == MODE_CMP && run_rise |=> st.out_level == $past(st.oc))
        else $error("initial level not loaded on run rise");

    a_timer_no_pin: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        st.mode == MODE_TMR && !$changed(st.mode) |-> !tm_out_en)
        else $error("pin driven in timer mode");

    a_full_duty: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
        clk_en && st.mode == MODE_PWM && st.act[1] && duty >= period && {1'b0, st.cnt} < period
        |=> st.out_level == $past(st.oc))
        else $error("full duty not held active");

    a_pwm_force: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        clk_en && st.mode == MODE_PWM && st.act == ACT_FORCE_HIGH |=> st.out_level)
        else $error("forced high level not held");

    a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
        tick && match_a |=> st.flag_a)
        else $error("A flag lost on match");
endmodule
